//--- src/dcc_chan_if.sv
// carrier between the top and one change-detect channel
`timescale 1ns/100ps
interface dcc_chan_if;
   logic cmp_level; // polarity-corrected comparator output
   logic capture; // config read or write this cycle
   logic flag_wr; // software write of the change flag
   logic flag_wr_data; // value written to the flag
   logic flag; // sticky change flag
   logic mismatch; // reference and sample differ
   modport top (output cmp_level, capture, flag_wr, flag_wr_data, input flag, mismatch);
   modport chan (input cmp_level, capture, flag_wr, flag_wr_data, output flag, mismatch);
endinterface : dcc_chan_if

//--- src/dcc_consts.svh
// constants for the dual comparator control and change-event block
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ----------------------------------------------------------------
// mode field codes
// ----------------------------------------------------------------
`define DCC_MODE_OFF_ANALOG 3'h0
`define DCC_MODE_THREE_MUX 3'h1
`define DCC_MODE_FOUR_MUX 3'h2
`define DCC_MODE_COMMON_REF 3'h3
`define DCC_MODE_TWO_INDEP 3'h4
`define DCC_MODE_ONE_INDEP 3'h5
`define DCC_MODE_OUT_REF 3'h6
`define DCC_MODE_OFF_DIGITAL 3'h7

// ----------------------------------------------------------------
// config register layout and reset value
// ----------------------------------------------------------------
`define DCC_CFG_MODE_LSB 0
`define DCC_CFG_MODE_MSB 2
`define DCC_CFG_SWITCH_BIT 3
`define DCC_CFG_INV_LSB 4
`define DCC_CFG_INV_MSB 5
`define DCC_CFG_OUT_LSB 6
`define DCC_CFG_OUT_MSB 7
`define DCC_CFG_RESET 6'h00

// ----------------------------------------------------------------
// pin order: 0 c1 in-, 1 c1 in+, 2 c2 in-, 3 c2 in+, 4 c1 out, 5 c2 out
// ----------------------------------------------------------------
`define DCC_PIN_NUM 6
// pin slots that carry comparator outputs in mode 110
`define DCC_PIN_OUT_ONE 4
`define DCC_PIN_OUT_TWO 5
`define DCC_MASK_OFF_ANALOG 6'h0F
`define DCC_MASK_THREE_MUX 6'h0F
`define DCC_MASK_FOUR_MUX 6'h0F
`define DCC_MASK_COMMON_REF 6'h0D
`define DCC_MASK_TWO_INDEP 6'h0F
`define DCC_MASK_ONE_INDEP 6'h0C
`define DCC_MASK_OUT_REF 6'h0D
`define DCC_MASK_OFF_DIGITAL 6'h00
`define DCC_MASK_OUT_PINS 6'h30
`define DCC_MASK_NONE 6'h00

`endif

//--- src/dcc_mismatch.sv
// two-latch mismatch detector and change flag for one comparator
`timescale 1ns/100ps
module dcc_mismatch
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // link to the top
   dcc_chan_if.chan ch
);
   logic ref_r, ref_nxt; // reference latch
   logic samp_r, samp_nxt; // per-cycle sample latch
   logic flag_r, flag_nxt; // sticky change flag

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      ref_nxt = ch.capture ? ch.cmp_level : ref_r;
      samp_nxt = ch.cmp_level;
      flag_nxt = flag_r;
      if (ch.flag_wr) begin
         flag_nxt = ch.flag_wr_data;
      end
      if (ch.mismatch) begin
         flag_nxt = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         ref_r <= 1'b0;
         samp_r <= 1'b0;
         flag_r <= 1'b0;
      end else begin
         ref_r <= ref_nxt;
         samp_r <= samp_nxt;
         flag_r <= flag_nxt;
      end
   end

   // change on a capture cycle is absorbed by the reference
   assign ch.mismatch = ref_r ^ samp_r;
   assign ch.flag = flag_r;
endmodule : dcc_mismatch

//--- src/dcc_pkg.sv
// types shared by the dual comparator control block
package dcc_pkg;
   // mode field value
   typedef logic [2:0] dcc_mode_t;
   // one bit per comparator channel
   typedef logic [1:0] dcc_pair_t;
   // one bit per comparator-related pin
   typedef logic [5:0] dcc_pins_t;
   // writable part of the config register
   typedef struct packed {
      dcc_pair_t invert;
      logic input_switch;
      dcc_mode_t mode;
   } dcc_cfg_t;
endpackage : dcc_pkg

//--- src/dcc_top.sv
// dual comparator mode decode, pin control and change-event logic
`timescale 1ns/100ps
`include "dcc_consts.svh"
module dcc_top
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // config register access
   input wire logic cfg_rd_en_in,
   input wire logic cfg_wr_en_in,
   input wire logic [7:0] cfg_wr_data_in,
   output logic [7:0] cfg_rd_data_out,
   // change flag access, one shared write strobe, one data and flag bit per comparator
   input wire logic flag_wr_en_in,
   input wire logic [1:0] flag_wr_data_in,
   output logic [1:0] change_flag_out,
   // interrupt enables
   input wire logic [1:0] comparator_change_enable_in,
   input wire logic peripheral_irq_enable_in,
   input wire logic global_irq_enable_in,
   output logic periph_req_out,
   output logic irq_req_out,
   // analog comparator side
   input wire logic [1:0] cmp_raw_in,
   output logic [1:0] cmp_enable_out,
   output logic [1:0] input_switch_out,
   output logic [1:0] comparator_output_bit_out,
   // port pins shared with the comparators
   input wire logic [5:0] pin_in,
   input wire logic [5:0] port_data_in,
   input wire logic [5:0] pin_direction_bit_in,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe_out,
   output logic [5:0] port_read_out
);

   // ----------------------------------------------------------------
   // configuration state
   // ----------------------------------------------------------------
   dcc_cfg_t cfg_r, cfg_nxt; // mode, switch and inversion bits
   dcc_pair_t cmp_level; // polarity-corrected outputs
   dcc_pair_t cmp_on; // comparator powered in this mode
   dcc_pins_t analog_mask; // pins with analog function
   dcc_pins_t digital_mask; // pins carrying comparator output
   dcc_pair_t switch_ok; // input switch honoured per channel
   dcc_pair_t flag_vec; // flags from the channels

   // config write updates writable bits only
   always_comb begin
      cfg_nxt = cfg_r;
      if (cfg_wr_en_in) begin
         cfg_nxt = cfg_wr_data_in[`DCC_CFG_INV_MSB:`DCC_CFG_MODE_LSB];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         cfg_r <= `DCC_CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   // mode sets pin functions
   always_comb begin
      analog_mask = `DCC_MASK_NONE;
      digital_mask = `DCC_MASK_NONE;
      cmp_on = 2'h3;
      switch_ok = 2'h0;
      case (cfg_r.mode)
         `DCC_MODE_OFF_ANALOG: begin
            // comparators off, inputs analog
            analog_mask = `DCC_MASK_OFF_ANALOG;
            cmp_on = 2'h0;
         end
         `DCC_MODE_THREE_MUX: begin
            analog_mask = `DCC_MASK_THREE_MUX;
            switch_ok = 2'h1;
         end
         `DCC_MODE_FOUR_MUX: begin
            analog_mask = `DCC_MASK_FOUR_MUX;
            switch_ok = 2'h3;
         end
         `DCC_MODE_COMMON_REF: begin
            analog_mask = `DCC_MASK_COMMON_REF;
         end
         `DCC_MODE_TWO_INDEP: begin
            analog_mask = `DCC_MASK_TWO_INDEP;
         end
         `DCC_MODE_ONE_INDEP: begin
            // only comparator two runs
            // switch on comparator two
            analog_mask = `DCC_MASK_ONE_INDEP;
            cmp_on = 2'h2;
            switch_ok = 2'h2;
         end
         `DCC_MODE_OUT_REF: begin
            analog_mask = `DCC_MASK_OUT_REF;
            digital_mask = `DCC_MASK_OUT_PINS;
         end
         `DCC_MODE_OFF_DIGITAL: begin
            // comparators off, all pins plain port
            analog_mask = `DCC_MASK_OFF_DIGITAL;
            cmp_on = 2'h0;
         end
         default: begin
            // unreachable with three bits, kept safe
            analog_mask = `DCC_MASK_OFF_ANALOG;
            cmp_on = 2'h0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // comparator output polarity
   // ----------------------------------------------------------------
   // a disabled comparator reads low before inversion, so the
   // status stays deterministic even with no bias current
   // inversion applied here
   assign cmp_level = (cmp_raw_in & cmp_on) ^ cfg_r.invert;

   // ----------------------------------------------------------------
   // change-detect channels
   // ----------------------------------------------------------------
   // one circuit per comparator
   generate
      for (genvar gi = 0; gi < 2; gi++) begin : g_chan
         dcc_chan_if ch_if ();
         assign ch_if.capture = cfg_rd_en_in | cfg_wr_en_in;
         assign ch_if.cmp_level = cmp_level[gi];
         assign ch_if.flag_wr = flag_wr_en_in;
         assign ch_if.flag_wr_data = flag_wr_data_in[gi];
         assign flag_vec[gi] = ch_if.flag;
         dcc_mismatch u_mismatch (
            .sys_clk_in (sys_clk_in),
            .sys_rst_in (sys_rst_in),
            .ch (ch_if.chan)
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   logic [7:0] rd_data_r, rd_data_nxt; // config readback
   dcc_pair_t out_bit_r, out_bit_nxt; // status bits
   dcc_pair_t switch_r, switch_nxt; // inverting input select
   dcc_pair_t enable_r, enable_nxt; // comparator power
   dcc_pins_t pin_r, pin_nxt; // pin output values
   dcc_pins_t oe_r, oe_nxt; // pin drive enables
   dcc_pins_t port_rd_r, port_rd_nxt; // port read values
   logic periph_r, periph_nxt; // enabled request before global gate
   logic irq_r, irq_nxt; // interrupt request

   // output values, one cycle after their cause
   always_comb begin
      out_bit_nxt = cmp_level;
      rd_data_nxt = {cmp_level, cfg_r};
      switch_nxt = switch_ok & {2{cfg_r.input_switch}};
      enable_nxt = cmp_on;
      pin_nxt = port_data_in;
      if (digital_mask[`DCC_PIN_OUT_ONE]) begin
         pin_nxt[`DCC_PIN_OUT_ONE] = cmp_level[0];
      end
      if (digital_mask[`DCC_PIN_OUT_TWO]) begin
         pin_nxt[`DCC_PIN_OUT_TWO] = cmp_level[1];
      end
      oe_nxt = ~pin_direction_bit_in;
      port_rd_nxt = pin_in & ~analog_mask;
      periph_nxt = |(flag_vec & comparator_change_enable_in) & peripheral_irq_enable_in;
      irq_nxt = periph_nxt & global_irq_enable_in;
   end

   // plain registering of the outputs
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         rd_data_r <= 8'h00;
         out_bit_r <= 2'h0;
         switch_r <= 2'h0;
         enable_r <= 2'h0;
         pin_r <= 6'h00;
         oe_r <= 6'h00;
         port_rd_r <= 6'h00;
         periph_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         rd_data_r <= rd_data_nxt;
         out_bit_r <= out_bit_nxt;
         switch_r <= switch_nxt;
         enable_r <= enable_nxt;
         pin_r <= pin_nxt;
         oe_r <= oe_nxt;
         port_rd_r <= port_rd_nxt;
         periph_r <= periph_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ----------------------------------------------------------------
   // port assignments
   // ----------------------------------------------------------------
   assign cfg_rd_data_out = rd_data_r;
   assign comparator_output_bit_out = out_bit_r;
   assign input_switch_out = switch_r;
   assign cmp_enable_out = enable_r;
   assign pin_out = pin_r;
   assign pin_oe_out = oe_r;
   assign port_read_out = port_rd_r;
   assign change_flag_out = flag_vec;
   assign periph_req_out = periph_r;
   assign irq_req_out = irq_r;

endmodule : dcc_top

//--- test/dcc_analog_model.sv
// far side model: comparator results and pin wires
`timescale 1ns/100ps
module dcc_analog_model (
   // clock and commanded levels
   input wire logic sys_clk_in,
   input wire logic [1:0] level_in,
   input wire logic [5:0] ext_in,
   // design pin side
   input wire logic [5:0] drv_in,
   input wire logic [5:0] oe_in,
   output logic [1:0] cmp_raw_out,
   output logic [5:0] pin_wire_out
);
   // result settles once a cycle, known from time zero
   initial cmp_raw_out = 2'h0;
   always @(posedge sys_clk_in) begin
      cmp_raw_out <= level_in;
   end
   // wire takes the driver only when enabled
   assign pin_wire_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule : dcc_analog_model

//--- test/dcc_top_sva.sv
// port assertions for the comparator block
`timescale 1ns/100ps
module dcc_top_sva (
   // clock, reset, strobes
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic cfg_rd_en_in,
   input wire logic cfg_wr_en_in,
   input wire logic flag_wr_en_in,
   input wire logic [1:0] flag_wr_data_in,
   // enables and far side
   input wire logic [1:0] comparator_change_enable_in,
   input wire logic peripheral_irq_enable_in,
   input wire logic global_irq_enable_in,
   input wire logic [1:0] cmp_raw_in,
   input wire logic [5:0] pin_direction_bit_in,
   // outputs watched
   input wire logic [7:0] cfg_rd_data_out,
   input wire logic [1:0] change_flag_out,
   input wire logic irq_req_out,
   input wire logic periph_req_out,
   input wire logic [1:0] comparator_output_bit_out,
   input wire logic [5:0] pin_oe_out,
   input wire logic [5:0] port_read_out
);
   // mode as shown on the read port
   wire [2:0] md = cfg_rd_data_out[2:0];
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   AST_RST: assert property ($fell(sys_rst_in) |-> cfg_rd_data_out == 8'h00)
      else $error("config not cleared by reset");
   AST_ANALOG: assert property (md == 3'h0 && $past(md) == 3'h0 |-> port_read_out[3:0] == 4'h0)
      else $error("analog pin read not zero");
   AST_OE: assert property (!$past(sys_rst_in) |-> pin_oe_out == ~$past(pin_direction_bit_in))
      else $error("pin enable wrong");
   AST_INV: assert property (($stable(md) && md == 3'h4 && $stable(cmp_raw_in)
      && $stable(cfg_rd_data_out[5:4]))[*3]
      |-> comparator_output_bit_out == (cmp_raw_in ^ cfg_rd_data_out[5:4]))
      else $error("status polarity wrong");
   AST_CHANGE: assert property (md == 3'h4 && $stable(md) && $changed(cmp_raw_in[0])
      && !cfg_rd_en_in && !cfg_wr_en_in |-> ##[1:4] change_flag_out[0])
      else $error("change not flagged");
   AST_STICKY: assert property (change_flag_out[0] && !flag_wr_en_in |=> change_flag_out[0])
      else $error("flag dropped by itself");
   AST_SET: assert property (flag_wr_en_in && flag_wr_data_in == 2'h3 |=> change_flag_out == 2'h3)
      else $error("flag set write lost");
   AST_IRQ_ON: assert property ((change_flag_out[0] && comparator_change_enable_in[0]
      && peripheral_irq_enable_in && global_irq_enable_in)[*3] |-> irq_req_out)
      else $error("request missing");
   AST_NO_PE: assert property (!peripheral_irq_enable_in [*3] |-> !irq_req_out && !periph_req_out)
      else $error("request while masked");
   // main scenarios reached
   COV_IRQ: cover property (change_flag_out[0] && irq_req_out);
   COV_OUT: cover property (md == 3'h6 && pin_oe_out[4]);
   COV_CLR: cover property (flag_wr_en_in && change_flag_out[0]);
endmodule : dcc_top_sva

bind dcc_top dcc_top_sva chk_i (.sys_clk_in, .sys_rst_in, .cfg_rd_en_in, .cfg_wr_en_in,
   .flag_wr_en_in, .flag_wr_data_in, .comparator_change_enable_in, .peripheral_irq_enable_in,
   .global_irq_enable_in, .cmp_raw_in, .pin_direction_bit_in, .cfg_rd_data_out,
   .change_flag_out, .irq_req_out, .periph_req_out, .comparator_output_bit_out, .pin_oe_out,
   .port_read_out);

//--- test/testbench.sv
// self-checking bench for the comparator block
`timescale 1ns/100ps
module testbench;
   // stimulus and observed outputs
   logic sys_clk_in = 1'b0, sys_rst_in = 1'b1;
   logic rd = 1'b0, wr = 1'b0, fw = 1'b0, pe = 1'b0, ge = 1'b0, preq, irq;
   logic [7:0] wd = 8'h00, rdat;
   logic [1:0] fd = 2'h0, ce = 2'h0, lvl = 2'h0, raw, flg, cen, isw, cob;
   logic [5:0] pdat = 6'h2A, dir = 6'h3F, ext = 6'h3B, pin, pout, poe, prd;
   logic [1:0] seen_cob = 2'h0; // software's own record of the status bits
   // per-mode expectations: analog mask, power, switch
   logic [5:0] msk [8] = '{6'h0F, 6'h0F, 6'h0F, 6'h0D, 6'h0F, 6'h0C, 6'h0D, 6'h00};
   logic [1:0] pwr [8] = '{2'h0, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h3, 2'h0};
   logic [1:0] swt [8] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h0, 2'h2, 2'h0, 2'h0};
   int fail_count = 0, n_compared = 0, cyc = 0;
   always #5 sys_clk_in = ~sys_clk_in;
   dcc_top uut (.sys_clk_in, .sys_rst_in, .cfg_rd_en_in(rd), .cfg_wr_en_in(wr),
      .cfg_wr_data_in(wd), .cfg_rd_data_out(rdat), .flag_wr_en_in(fw), .flag_wr_data_in(fd),
      .change_flag_out(flg), .comparator_change_enable_in(ce), .peripheral_irq_enable_in(pe),
      .global_irq_enable_in(ge), .periph_req_out(preq), .irq_req_out(irq), .cmp_raw_in(raw),
      .cmp_enable_out(cen), .input_switch_out(isw), .comparator_output_bit_out(cob),
      .pin_in(pin), .port_data_in(pdat), .pin_direction_bit_in(dir), .pin_out(pout),
      .pin_oe_out(poe), .port_read_out(prd));
   dcc_analog_model pm (.sys_clk_in, .level_in(lvl), .ext_in(ext), .drv_in(pout),
      .oe_in(poe), .cmp_raw_out(raw), .pin_wire_out(pin));
   // compare and count
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // wait, then land on a settled point
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
   endtask : tick
   // one strobe: 0 config read, 1 config write, 2 flag write
   task automatic op(input int k, input logic [7:0] d);
      @(posedge sys_clk_in);
      rd <= (k == 0);
      wr <= (k == 1);
      fw <= (k == 2);
      wd <= d;
      fd <= d[1:0];
      @(posedge sys_clk_in);
      {rd, wr, fw} <= 3'h0;
   endtask : op
   // analog levels, directions, enables {global, periph, chan}
   task automatic drive(input logic [1:0] l, input logic [5:0] d, input logic [3:0] e);
      @(posedge sys_clk_in);
      lvl <= l;
      dir <= d;
      {ge, pe, ce} <= e;
   endtask : drive
   // verdict and end of run
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   // hang guard
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      repeat (5) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      tick(1);
      chk("config", rdat, 8'h00);
      chk("power", cen, 2'h0);
      // enables stay off
      // every mode, switch bit set, read-only status bits written as ones
      for (int m = 0; m < 8; m++) begin
         op(1, 8'hC8 | m[7:0]);
         tick(3);
         chk("config", rdat, 8'h08 | m[7:0]);
         chk("port read", prd, ~msk[m] & 6'h3B);
         chk("power", cen, pwr[m]);
         chk("switch", isw, swt[m]);
      end
      // polarity and status
      drive(2'h1, 6'h3F, 4'h0);
      op(1, 8'h04);
      tick(3);
      chk("status", cob, 2'h1);
      chk("status read", rdat[7:6], 2'h1);
      op(1, 8'h34);
      tick(3);
      chk("inverted", cob, 2'h2);
      // output pins, drivers on per direction
      drive(2'h1, 6'h0F, 4'h0);
      op(1, 8'h06);
      tick(3);
      chk("out pins", pout[5:4], 2'h1);
      chk("out enable", poe[5:4], 2'h3);
      op(1, 8'h04);
      tick(3);
      chk("port pins", pout[5:4], pdat[5:4]);
      // change flag on comparator one
      op(0, 8'h00);
      op(2, 8'h00);
      tick(3);
      chk("flag clear", flg, 2'h0);
      seen_cob = cob;
      drive(2'h0, 6'h3F, 4'h0);
      tick(5);
      chk("flag", flg, 2'h1);
      chk("which changed", cob ^ seen_cob, 2'h1);
      chk("masked", irq, 1'b0);
      op(2, 8'h00);
      tick(3);
      chk("held flag", flg, 2'h1);
      drive(2'h0, 6'h3F, 4'hF);
      tick(4);
      chk("irq", irq, 1'b1);
      chk("periph", preq, 1'b1);
      op(0, 8'h00);
      op(2, 8'h00);
      tick(4);
      chk("flag off", flg, 2'h0);
      chk("irq off", irq, 1'b0);
      // comparator two, write ends mismatch
      drive(2'h2, 6'h3F, 4'hF);
      tick(5);
      chk("flag two", flg, 2'h2);
      op(1, 8'h04);
      op(2, 8'h00);
      tick(3);
      chk("after write", flg, 2'h0);
      // short pulse returns to old state
      drive(2'h3, 6'h3F, 4'hF);
      drive(2'h2, 6'h3F, 4'hF);
      tick(5);
      chk("pulse flag", flg, 2'h1);
      op(2, 8'h00);
      tick(3);
      chk("pulse clear", flg, 2'h0);
      // software set
      op(2, 8'h03);
      tick(4);
      chk("set flag", flg, 2'h3);
      chk("set irq", irq, 1'b1);
      op(2, 8'h00);
      tick(3);
      chk("set clear", flg, 2'h0);
      // mid-run reset with a busy config and both flags up
      op(1, 8'h3C);
      op(2, 8'h03);
      @(posedge sys_clk_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      tick(1);
      chk("reset config", rdat, 8'h00);
      chk("reset power", cen, 2'h0);
      chk("reset flags", flg, 2'h0);
      chk("reset requests", {preq, irq}, 2'h0);
      results();
   end
endmodule : testbench
